// *** common/lca_consts.svh ***
`ifndef LCA_CONSTS_SVH
`define LCA_CONSTS_SVH

// ==========================================
// Register byte addresses
`define LCA_OFF_LUMA_OFFSET 8'h28
`define LCA_OFF_EVEN_CTRL   8'h2C
`define LCA_OFF_LUMA_GAIN   8'h30
`define LCA_OFF_U_GAIN      8'h34
`define LCA_OFF_V_GAIN      8'h38
`define LCA_OFF_ODD_CTRL    8'hAC

// ==========================================
// Reset values
`define LCA_RST_LUMA_OFFSET 8'h00
`define LCA_RST_CTRL        8'h20
`define LCA_RST_LUMA_GAIN   8'hD8
`define LCA_RST_U_GAIN      8'hFE
`define LCA_RST_V_GAIN      8'hB4
`define LCA_RD_UNMAPPED     8'h00

// ==========================================
// Unity gains and output limits
`define LCA_UNITY_LUMA 9'h0D8
`define LCA_UNITY_U    9'h0FE
`define LCA_UNITY_V    9'h0B4
`define LCA_Y_LO       8'h00
`define LCA_Y_HI       8'hFF
`define LCA_C_LO       8'h80
`define LCA_C_HI       8'h7F
`define LCA_Y_MID      8'h80
`define LCA_DELAY_W    10

`endif

// *** common/lca_pkg.sv ***
package lca_pkg;
	typedef logic [7:0]         lca_byte_t;
	typedef logic [8:0]         lca_gain_t;
	typedef logic signed [10:0] lca_wide_t;
	typedef struct packed {
		logic luma_trap_bypass;
		logic yc_input_sel;
		logic luma_decim_bypass;
		logic chroma_order_invert;
		logic reserved;
		logic luma_gain_top_bit;
		logic u_gain_top_bit;
		logic v_gain_top_bit;
	} lca_ctrl_s;
endpackage

// *** common/lca_samp_if.sv ***
`timescale 1ns/1ps
interface lca_samp_if;
	logic              valid;
	logic signed [8:0] samp;
	logic [8:0]        gain;
	logic              res_valid;
	logic signed [10:0] res;
	modport drv  (output valid, samp, gain, input res_valid, res);
	modport unit (input valid, samp, gain, output res_valid, res);
endinterface

// *** rtl/lca_gain.sv ***
`timescale 1ns/1ps
`include "lca_consts.svh"
module lca_gain #(
	parameter logic [8:0] UNITY = `LCA_UNITY_LUMA
) (
	input wire logic clock,
	input wire logic rst,
	lca_samp_if.unit s
);
	import lca_pkg::*;

	// ==========================================
	// Scale by gain over unity, rounded half away from zero
	wire logic signed [19:0] prod = s.samp * $signed({1'b0, s.gain});
	wire logic signed [19:0] half = $signed({12'h000, UNITY[8:1]});
	wire logic signed [19:0] dvsr = $signed({11'h000, UNITY});
	wire logic signed [19:0] rnd  = prod[19] ? prod - half : prod + half;
	wire logic signed [19:0] quo  = rnd / dvsr;

	always_ff @(posedge clock) begin
		if (rst) begin
			s.res_valid <= 1'b0;
			s.res       <= '0;
		end else begin
			s.res_valid <= s.valid;
			if (s.valid) begin
				s.res <= quo[10:0]; // [RULE13] [RULE15] [RULE16]
			end
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	unity_gain_pass_a: assert property ( // [RULE13]
		s.valid && s.gain == UNITY |=> s.res_valid && s.res == lca_wide_t'($past(s.samp)))
		else $error("unity gain altered the sample");
	double_gain_a: assert property ( // [RULE15]
		s.valid && s.gain == {UNITY[7:0], 1'b0} && s.samp == 9'sh010 |=> s.res == 11'sh020)
		else $error("double gain did not double the sample");
endmodule

// *** rtl/lca_luma_chroma_adjust.sv ***
`timescale 1ns/1ps
`include "lca_consts.svh"
// How it works
// [RULE1] Signed brightness byte, -128 to +127, is added to every luma sample.
// [RULE2] One brightness unit moves luma by one LSB of the range.
// [RULE3] Brightness resets to zero so luma passes unchanged.
// [RULE4] Control bit 7 low inserts the luma notch, high bypasses it.
// [RULE5] Software keeps the notch bypassed for monochrome video.
// [RULE6] Control bit 6 high picks Y/C and drops notch; low picks composite.
// [RULE7] Control bit 5 low enables luma decimation, high bypasses; resets to one.
// [RULE8] Control bit 4 inverts the Cb/Cr order at line start.
// [RULE9] Even start delay with bit clear gives Cb first; odd needs bit set.
// [RULE10] Software writes only zero into reserved control bit 3.
// [RULE11] Control bit 2 is bit 8 above the luma gain low byte.
// [RULE12] Control bits 1 and 0 are bit 8 of U and V gains.
// [RULE13] Luma is multiplied by the 9-bit gain, 216 meaning unity.
// [RULE14] Both field control registers reset with only decimation bypass set.
// [RULE15] U gain scales U with 254 as unity; low byte resets there.
// [RULE16] V gain scales V with 180 as unity; low byte resets there.
// [RULE17] Start delay counts pixels from line reset fall to active video.
// [RULE18] Luma after gain and offset clamps to 0..255 instead of wrapping.
module lca_luma_chroma_adjust (
	input  wire logic               clock,
	input  wire logic               rst,
	input  wire logic [7:0]         reg_addr,
	input  wire lca_pkg::lca_byte_t reg_wdata,
	input  wire logic               reg_wr,
	input  wire logic               reg_rd,
	output lca_pkg::lca_byte_t      reg_rdata,
	input  wire logic               in_valid,
	input  wire lca_pkg::lca_byte_t in_y,
	input  wire lca_pkg::lca_byte_t in_u,
	input  wire lca_pkg::lca_byte_t in_v,
	input  wire logic               field_odd,
	input  wire logic               line_sync_reset,
	input  wire logic [9:0]         horiz_start_delay,
	output logic                    out_valid,
	output lca_pkg::lca_byte_t      out_y,
	output lca_pkg::lca_byte_t      out_u,
	output lca_pkg::lca_byte_t      out_v,
	output logic                    out_active,
	output logic                    out_is_cr,
	output logic                    luma_trap_on,
	output logic                    chroma_adc_on,
	output logic                    luma_decim_on,
	output logic                    yc_input_sel
);
	import lca_pkg::*;

	// ==========================================
	// Register file
	lca_byte_t luma_offset_reg;
	lca_ctrl_s even_field_misc_control;
	lca_byte_t luma_gain_low_reg;
	lca_byte_t u_gain_low_reg;
	lca_byte_t v_gain_low_reg;
	lca_ctrl_s odd_field_misc_control;

	wire logic hit_offset = reg_addr == `LCA_OFF_LUMA_OFFSET;
	wire logic hit_even   = reg_addr == `LCA_OFF_EVEN_CTRL;
	wire logic hit_lgain  = reg_addr == `LCA_OFF_LUMA_GAIN;
	wire logic hit_ugain  = reg_addr == `LCA_OFF_U_GAIN;
	wire logic hit_vgain  = reg_addr == `LCA_OFF_V_GAIN;
	wire logic hit_odd    = reg_addr == `LCA_OFF_ODD_CTRL;

	// Reserved bit 3 is stored as written; it steers nothing, so a nonzero
	// write is harmless here but reads back as written.
	always_ff @(posedge clock) begin
		if (rst) begin
			luma_offset_reg         <= `LCA_RST_LUMA_OFFSET; // [RULE3]
			even_field_misc_control <= `LCA_RST_CTRL; // [RULE14]
			odd_field_misc_control  <= `LCA_RST_CTRL; // [RULE14]
			luma_gain_low_reg       <= `LCA_RST_LUMA_GAIN;
			u_gain_low_reg          <= `LCA_RST_U_GAIN; // [RULE15]
			v_gain_low_reg          <= `LCA_RST_V_GAIN; // [RULE16]
		end else if (reg_wr) begin
			if (hit_offset) luma_offset_reg <= reg_wdata;
			if (hit_even) even_field_misc_control <= reg_wdata;
			if (hit_odd) odd_field_misc_control <= reg_wdata;
			if (hit_lgain) luma_gain_low_reg <= reg_wdata;
			if (hit_ugain) u_gain_low_reg <= reg_wdata;
			if (hit_vgain) v_gain_low_reg <= reg_wdata;
		end
	end

	wire lca_byte_t rd_mux =
		hit_offset ? luma_offset_reg :
		hit_even   ? lca_byte_t'(even_field_misc_control) :
		hit_lgain  ? luma_gain_low_reg :
		hit_ugain  ? u_gain_low_reg :
		hit_vgain  ? v_gain_low_reg :
		hit_odd    ? lca_byte_t'(odd_field_misc_control) :
		`LCA_RD_UNMAPPED;

	// A read in the same cycle as a write to that register returns the old value.
	always_ff @(posedge clock) begin
		if (rst) begin
			reg_rdata <= `LCA_RD_UNMAPPED;
		end else if (reg_rd) begin
			reg_rdata <= rd_mux;
		end
	end

	// ==========================================
	// Field control selection and gains
	wire lca_ctrl_s ctrl_sel = field_odd ? odd_field_misc_control : even_field_misc_control;
	wire lca_gain_t luma_gain = {ctrl_sel.luma_gain_top_bit, luma_gain_low_reg}; // [RULE11]
	wire lca_gain_t u_gain = {ctrl_sel.u_gain_top_bit, u_gain_low_reg}; // [RULE12]
	wire lca_gain_t v_gain = {ctrl_sel.v_gain_top_bit, v_gain_low_reg}; // [RULE12]

	// The downstream filters are outside this block; they follow these enables.
	wire logic next_trap_on = ~ctrl_sel.luma_trap_bypass & ~ctrl_sel.yc_input_sel; // [RULE4] [RULE6]

	always_ff @(posedge clock) begin
		if (rst) begin
			luma_trap_on  <= 1'b1;
			chroma_adc_on <= 1'b0;
			luma_decim_on <= 1'b0;
			yc_input_sel  <= 1'b0;
		end else begin
			luma_trap_on  <= next_trap_on;
			chroma_adc_on <= ctrl_sel.yc_input_sel; // [RULE6]
			luma_decim_on <= ~ctrl_sel.luma_decim_bypass; // [RULE7]
			yc_input_sel  <= ctrl_sel.yc_input_sel; // [RULE6]
		end
	end

	// ==========================================
	// Gain stage, one cycle
	lca_samp_if y_if ();
	lca_samp_if u_if ();
	lca_samp_if v_if ();

	assign y_if.valid = in_valid;
	assign y_if.samp  = $signed({1'b0, in_y});
	assign y_if.gain  = luma_gain; // [RULE13]
	assign u_if.valid = in_valid;
	assign u_if.samp  = $signed({in_u[7], in_u});
	assign u_if.gain  = u_gain; // [RULE15]
	assign v_if.valid = in_valid;
	assign v_if.samp  = $signed({in_v[7], in_v});
	assign v_if.gain  = v_gain; // [RULE16]

	lca_gain #(.UNITY(`LCA_UNITY_LUMA)) u_ygain (
		.clock (clock),
		.rst   (rst),
		.s     (y_if)
	);
	lca_gain #(.UNITY(`LCA_UNITY_U)) u_ugain (
		.clock (clock),
		.rst   (rst),
		.s     (u_if)
	);
	lca_gain #(.UNITY(`LCA_UNITY_V)) u_vgain (
		.clock (clock),
		.rst   (rst),
		.s     (v_if)
	);

	// ==========================================
	// Line start and chroma phase
	logic sync_prev;
	logic ph_active;
	logic ph_cr;

	// Line reset comes from the sync logic on this clock, so it is not resynchronised.
	always_ff @(posedge clock) begin
		if (rst) begin
			sync_prev <= 1'b0;
		end else begin
			sync_prev <= line_sync_reset;
		end
	end

	wire logic sync_fall = sync_prev & ~line_sync_reset; // [RULE17]

	lca_phase #(.DELAY_W(`LCA_DELAY_W)) u_phase (
		.clock        (clock),
		.rst          (rst),
		.sync_fall    (sync_fall),
		.pix_valid    (in_valid),
		.start_delay  (horiz_start_delay),
		.order_invert (ctrl_sel.chroma_order_invert), // [RULE8]
		.tag_active   (ph_active),
		.tag_cr       (ph_cr)
	);

	// ==========================================
	// Brightness and limiting
	// Offset is applied after gain, so brightness steps stay one LSB at any contrast.
	wire lca_wide_t luma_offset = lca_wide_t'($signed(luma_offset_reg));
	wire lca_wide_t y_sum = y_if.res + luma_offset; // [RULE1] [RULE2]
	wire logic y_neg = y_sum[10];
	wire logic y_big = ~y_sum[10] & |y_sum[9:8];
	wire lca_byte_t y_lim = y_neg ? `LCA_Y_LO : y_big ? `LCA_Y_HI : y_sum[7:0]; // [RULE18]

	function automatic lca_byte_t clamp_c(input lca_wide_t x);
		logic fits;
		fits = (x[10:7] == 4'h0) || (x[10:7] == 4'hF);
		return fits ? x[7:0] : (x[10] ? `LCA_C_LO : `LCA_C_HI);
	endfunction

	wire lca_byte_t u_lim = clamp_c(u_if.res);
	wire lca_byte_t v_lim = clamp_c(v_if.res);

	always_ff @(posedge clock) begin
		if (rst) begin
			out_valid  <= 1'b0;
			out_y      <= '0;
			out_u      <= '0;
			out_v      <= '0;
			out_active <= 1'b0;
			out_is_cr  <= 1'b0;
		end else begin
			out_valid <= y_if.res_valid;
			if (y_if.res_valid) begin
				out_y      <= y_lim;
				out_u      <= u_lim;
				out_v      <= v_lim;
				out_active <= ph_active;
				out_is_cr  <= ph_cr; // [RULE9]
			end
		end
	end

	// ==========================================
	// Checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	sequence s_unity_in;
		in_valid && luma_gain == `LCA_UNITY_LUMA;
	endsequence

	sequence s_mid_unity_in;
		s_unity_in and (in_y == `LCA_Y_MID);
	endsequence

	offset_reset_zero_a: assert property ($past(rst) |-> luma_offset_reg == `LCA_RST_LUMA_OFFSET) // [RULE3]
		else $error("brightness not zero after reset");
	ctrl_reset_value_a: assert property ( // [RULE14]
		$past(rst) |-> even_field_misc_control == `LCA_RST_CTRL && odd_field_misc_control == `LCA_RST_CTRL)
		else $error("field control not reset to decimation bypass only");
	chroma_gain_reset_a: assert property ( // [RULE16]
		$past(rst) |-> u_gain_low_reg == `LCA_RST_U_GAIN && v_gain_low_reg == `LCA_RST_V_GAIN)
		else $error("chroma gain low bytes not at unity after reset");
	pipe_latency_a: assert property (in_valid |-> ##2 out_valid) // [RULE1]
		else $error("sample did not emerge two cycles later");
	unity_passthru_a: assert property ( // [RULE13]
		s_unity_in ##1 (luma_offset_reg == `LCA_RST_LUMA_OFFSET) |=> out_y == $past(in_y, 2))
		else $error("unity gain with zero offset changed luma");
	luma_offset_add_a: assert property ( // [RULE2]
		s_mid_unity_in ##1 $stable(luma_offset_reg) |=> out_y == $past(in_y, 2) + $past(luma_offset_reg))
		else $error("brightness offset not added one LSB per unit");
	luma_clamp_hi_a: assert property (y_if.res_valid && y_big |=> out_y == `LCA_Y_HI) // [RULE18]
		else $error("luma overflow wrapped instead of clamping");
	luma_clamp_lo_a: assert property (y_if.res_valid && y_neg |=> out_y == `LCA_Y_LO) // [RULE18]
		else $error("luma underflow wrapped instead of clamping");
	notch_ctrl_a: assert property ( // [RULE4]
		ctrl_sel.luma_trap_bypass || ctrl_sel.yc_input_sel |=> !luma_trap_on)
		else $error("luma notch left in while bypassed or Y/C");
	decim_ctrl_a: assert property (1'b1 |=> luma_decim_on == !$past(ctrl_sel.luma_decim_bypass)) // [RULE7]
		else $error("decimation enable does not follow control bit");
	yc_adc_a: assert property (1'b1 |=> chroma_adc_on == $past(ctrl_sel.yc_input_sel)) // [RULE6]
		else $error("chroma converter enable does not follow input type");
	top_bit_a: assert property ( // [RULE11]
		in_valid && ctrl_sel.luma_gain_top_bit && luma_gain_low_reg == 8'hB0 && in_y == 8'h40 |=> y_if.res == 11'sh080)
		else $error("luma gain top bit misplaced");
endmodule

// *** rtl/lca_phase.sv ***
`timescale 1ns/1ps
`include "lca_consts.svh"
module lca_phase #(
	parameter int DELAY_W = `LCA_DELAY_W
) (
	input  wire logic               clock,
	input  wire logic               rst,
	input  wire logic               sync_fall,
	input  wire logic               pix_valid,
	input  wire logic [DELAY_W-1:0] start_delay,
	input  wire logic               order_invert,
	output logic                    tag_active,
	output logic                    tag_cr
);
	logic [DELAY_W-1:0] cnt;
	logic               active_r;
	logic               phase_r;
	logic               inv_line;

	// ==========================================
	// Pixel count since the line reset fell
	wire logic [DELAY_W-1:0] next_cnt = &cnt ? cnt : cnt + DELAY_W'(1);
	wire logic hit = pix_valid & ~active_r & (cnt == start_delay); // [RULE17]

	// A pixel that arrives in the fall cycle itself is tagged inactive and not counted.
	always_ff @(posedge clock) begin
		if (rst) begin
			cnt        <= '0;
			active_r   <= 1'b0;
			phase_r    <= 1'b0;
			inv_line   <= 1'b0;
			tag_active <= 1'b0;
			tag_cr     <= 1'b0;
		end else if (sync_fall) begin
			cnt        <= '0;
			active_r   <= 1'b0;
			phase_r    <= order_invert; // [RULE8]
			inv_line   <= order_invert;
			tag_active <= 1'b0;
		end else if (pix_valid) begin
			cnt        <= next_cnt;
			active_r   <= active_r | hit; // [RULE17]
			phase_r    <= ~phase_r;
			tag_active <= active_r | hit;
			tag_cr     <= phase_r; // [RULE9]
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	phase_load_a: assert property (sync_fall |=> phase_r == $past(order_invert)) // [RULE8]
		else $error("chroma phase not loaded at line start");
	first_pixel_cb_a: assert property ( // [RULE9]
		hit && !sync_fall |=> tag_active && tag_cr == ($past(start_delay[0]) ^ inv_line))
		else $error("first active pixel has wrong chroma phase");
	start_count_a: assert property ( // [RULE17]
		pix_valid && !sync_fall && !active_r && cnt != start_delay |=> !tag_active)
		else $error("active video started before the start delay");
endmodule

// *** verif/tb_lca_luma_chroma_adjust.sv ***
`timescale 1ns/1ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin failures++; \
	$display("wrong value at %0t ns: got %h expected %h", $time, (got), (exp)); end end
module tb_lca_luma_chroma_adjust;
	import lca_pkg::*;

	// ==========================================
	// Signals and design instance
	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  reg_addr = 8'h00;
	lca_byte_t   reg_wdata = 8'h00;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	lca_byte_t   reg_rdata;
	logic        in_valid = 1'b0;
	lca_byte_t   in_y = 8'h00;
	lca_byte_t   in_u = 8'h00;
	lca_byte_t   in_v = 8'h00;
	logic        field_odd = 1'b0;
	logic        line_sync_reset = 1'b0;
	logic [9:0]  horiz_start_delay = 10'h000;
	logic        out_valid;
	lca_byte_t   out_y;
	lca_byte_t   out_u;
	lca_byte_t   out_v;
	logic        out_active;
	logic        out_is_cr;
	logic        luma_trap_on;
	logic        chroma_adc_on;
	logic        luma_decim_on;
	logic        yc_input_sel;
	int          failures = 0;
	int          num_checks = 0;
	int          cycles = 0;
	logic [1:0]  tags_q[$];
	logic [7:0]  ctl_tab[4] = '{8'h00, 8'h80, 8'h40, 8'h20};
	logic [3:0]  en_tab[4] = '{4'b1010, 4'b0010, 4'b0111, 4'b1000};

	lca_luma_chroma_adjust lca_luma_chroma_adjust_inst (
		.clock             (clock),
		.rst               (rst),
		.reg_addr          (reg_addr),
		.reg_wdata         (reg_wdata),
		.reg_wr            (reg_wr),
		.reg_rd            (reg_rd),
		.reg_rdata         (reg_rdata),
		.in_valid          (in_valid),
		.in_y              (in_y),
		.in_u              (in_u),
		.in_v              (in_v),
		.field_odd         (field_odd),
		.line_sync_reset   (line_sync_reset),
		.horiz_start_delay (horiz_start_delay),
		.out_valid         (out_valid),
		.out_y             (out_y),
		.out_u             (out_u),
		.out_v             (out_v),
		.out_active        (out_active),
		.out_is_cr         (out_is_cr),
		.luma_trap_on      (luma_trap_on),
		.chroma_adc_on     (chroma_adc_on),
		.luma_decim_on     (luma_decim_on),
		.yc_input_sel      (yc_input_sel)
	);

	always #12.5 clock = ~clock;

	// The whole run needs well under a thousand cycles, so this ceiling only trips on a hang.
	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			report_and_stop();
		end
	end

	// Sampling on the falling edge keeps the capture clear of the rising-edge updates.
	always @(negedge clock) begin
		if (out_valid === 1'b1)
			tags_q.push_back({out_active, out_is_cr});
	end

	// ==========================================
	// Access tasks
	task automatic report_and_stop();
		$display("checks %0d, mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input lca_byte_t d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask

	task automatic rchk(input logic [7:0] a, input lca_byte_t exp);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		`CHK(reg_rdata, exp)
	endtask

	// One pixel in, then the result is looked at while it stands.
	task automatic pix(input lca_byte_t y, input lca_byte_t u, input lca_byte_t v, input logic odd,
		input lca_byte_t ey, input lca_byte_t eu, input lca_byte_t ev);
		@(posedge clock);
		in_valid <= 1'b1;
		in_y <= y;
		in_u <= u;
		in_v <= v;
		field_odd <= odd;
		@(posedge clock);
		in_valid <= 1'b0;
		@(posedge clock);
		#1;
		`CHK(out_valid, 1'b1)
		`CHK({out_y, out_u, out_v}, {ey, eu, ev})
		@(posedge clock);
		#1;
		`CHK(out_valid, 1'b0)
	endtask

	// Streams n pixels right after a line start and checks where active video and Cb begin.
	task automatic line(input logic [9:0] dly, input logic inv, input int n);
		tags_q.delete();
		@(posedge clock);
		horiz_start_delay <= dly;
		line_sync_reset <= 1'b1;
		@(posedge clock);
		line_sync_reset <= 1'b0;
		@(posedge clock);
		in_valid <= 1'b1;
		repeat (n) @(posedge clock);
		in_valid <= 1'b0;
		repeat (4) @(posedge clock);
		`CHK(tags_q.size(), n)
		for (int k = 0; k < n && k < tags_q.size(); k++) begin
			`CHK(tags_q[k], {k >= int'(dly), inv ^ k[0]})
		end
	endtask

	// ==========================================
	// Test sequence
	initial begin
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		#1;
		`CHK({luma_trap_on, chroma_adc_on, luma_decim_on, yc_input_sel}, 4'b1000)
		rchk(8'h28, 8'h00);
		rchk(8'h2C, 8'h20);
		rchk(8'hAC, 8'h20);
		rchk(8'h30, 8'hD8);
		rchk(8'h34, 8'hFE);
		rchk(8'h38, 8'hB4);
		pix(8'h80, 8'h10, 8'hF0, 1'b0, 8'h80, 8'h10, 8'hF0);
		wr(8'h28, 8'h05);
		wr(8'h3C, 8'hAA);
		rchk(8'h3C, 8'h00);
		rchk(8'h28, 8'h05);
		pix(8'h80, 8'h00, 8'h00, 1'b0, 8'h85, 8'h00, 8'h00);
		wr(8'h28, 8'hFF);
		pix(8'h80, 8'h00, 8'h00, 1'b0, 8'h7F, 8'h00, 8'h00);
		wr(8'h28, 8'h80);
		pix(8'h90, 8'h00, 8'h00, 1'b0, 8'h10, 8'h00, 8'h00);
		pix(8'h10, 8'h00, 8'h00, 1'b0, 8'h00, 8'h00, 8'h00);
		wr(8'h28, 8'h7F);
		pix(8'hF0, 8'h00, 8'h00, 1'b0, 8'hFF, 8'h00, 8'h00);
		wr(8'h28, 8'h00);
		wr(8'h30, 8'hB0);
		pix(8'hD8, 8'h00, 8'h00, 1'b0, 8'hB0, 8'h00, 8'h00);
		wr(8'h2C, 8'h27);
		wr(8'h34, 8'hFC);
		wr(8'h38, 8'h68);
		pix(8'h40, 8'h10, 8'h10, 1'b0, 8'h80, 8'h20, 8'h20);
		pix(8'hD8, 8'hF0, 8'h70, 1'b0, 8'hFF, 8'hE0, 8'h7F);
		pix(8'hD8, 8'h00, 8'h00, 1'b1, 8'hB0, 8'h00, 8'h00);
		rchk(8'h2C, 8'h27);
		// The remaining scenarios program the even-field control, so the even field must be selected.
		@(posedge clock);
		field_odd <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			wr(8'h2C, ctl_tab[i]);
			repeat (3) @(posedge clock);
			#1;
			`CHK({luma_trap_on, chroma_adc_on, luma_decim_on, yc_input_sel}, en_tab[i])
		end
		line(10'd2, 1'b0, 5);
		wr(8'h2C, 8'h30);
		line(10'd3, 1'b1, 6);
		report_and_stop();
	end
endmodule
